/* rtl/pbcs_pkg.sv */
// Package for the PLL base clock selector: register map, field positions, reset values.
// Assumes an APB master with 32-bit data and word-aligned register addresses.
package pbcs_pkg;

  // Register byte addresses on the APB bus
  localparam logic [7:0] CTRL_ADDR  = 8'h00;
  localparam logic [7:0] BWC_ADDR   = 8'h04;
  localparam logic [7:0] PROG_ADDR  = 8'h08;
  localparam int         ADDR_W     = 8;

  // pll_control field positions
  localparam int CTRL_IE_BIT   = 7;
  localparam int CTRL_FLAG_BIT = 6;
  localparam int CTRL_ON_BIT   = 5;
  localparam int CTRL_BCS_BIT  = 4;
  localparam logic [3:0] CTRL_UNIMP_VAL = 4'hf;

  // pll_bandwidth_control field positions
  localparam int BWC_AUTO_BIT = 7;
  localparam int BWC_LOCK_BIT = 6;
  localparam int BWC_ACQ_BIT  = 5;

  // pll_programming fields
  localparam int PROG_MUL_LSB = 4;
  localparam int PROG_RNG_LSB = 0;
  localparam logic [3:0] FIELD_RESET = 4'h6;
  localparam logic [3:0] FIELD_ZERO  = 4'h0;
  localparam logic [3:0] MUL_ONE     = 4'h1;

  // Transition stage depth in the crystal and VCO clock domains
  localparam int SYNC_STAGES = 3;

  typedef struct packed {
    logic       ie;
    logic       on;
    logic       base_clock_select;
    logic       auto_bw;
    logic       acq_man;
    logic [3:0] mul;
    logic [3:0] rng;
  } pbcs_cfg_t;

endpackage : pbcs_pkg

/* rtl/pbcs_top.sv */
// PLL base clock selector: register file over APB, lock flag logic and
// glitch-free switch between crystal and VCO clocks followed by divide-by-two.
// Assumes crystal and VCO clocks are asynchronous to CLK_I; lock detector is async.
//
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps

module pbcs_top
(
  input  wire logic        CLK_I,
  input  wire logic        RSTN_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  input  wire logic        CRYSTAL_CLOCK_I,
  input  wire logic        VCO_CLOCK_I,
  input  wire logic        LOCK_DETECT_I,
  input  wire logic        TRACKING_I,
  input  wire logic        OSCILLATOR_ENABLE_IN_I,
  input  wire logic        STOP_I,
  output logic             BASE_CLOCK_OUT_O,
  output logic             PLL_INTERRUPT_REQUEST_O,
  output logic             OSC_ENABLE_O,
  output logic             PLL_ENABLE_O,
  output logic             AUTO_BW_O,
  output logic             ACQ_CTRL_O,
  output logic      [3:0]  FEEDBACK_DIV_O,
  output logic      [3:0]  RANGE_SELECT_O
);

  pbcs_pkg::pbcs_cfg_t cfg_q;
  logic       flag_q;
  logic [1:0] lock_sync_q;
  logic [1:0] trk_sync_q;
  logic       lock_prev_q;
  logic       wr_en;
  logic       rd_en;
  logic       rd_setup;
  logic       flag_read;
  logic       ctrl_wr;
  logic       bwc_wr;
  logic       prog_wr;
  logic       lock_now;
  logic       lock_edge;
  logic       range_zero;
  logic       sel_vco;
  logic       new_on;
  logic       new_bcs;

  // Zero-wait-state slave: answer in the access cycle
  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = 1'b0;
  assign wr_en     = PSEL_I && PENABLE_I && PWRITE_I;
  assign rd_en     = PSEL_I && PENABLE_I && !PWRITE_I;
  // Read data is loaded in the setup cycle so it already stands in the access cycle
  assign rd_setup  = PSEL_I && !PENABLE_I && !PWRITE_I;
  assign ctrl_wr   = wr_en && (PADDR_I == pbcs_pkg::CTRL_ADDR);
  assign bwc_wr    = wr_en && (PADDR_I == pbcs_pkg::BWC_ADDR);
  assign prog_wr   = wr_en && (PADDR_I == pbcs_pkg::PROG_ADDR);

  assign range_zero = (cfg_q.rng == pbcs_pkg::FIELD_ZERO);
  assign sel_vco    = cfg_q.base_clock_select && !range_zero;

  // Lock detector and filter mode come from the analog side
  always_ff @(posedge CLK_I)
  begin
    if (!RSTN_I)
    begin
      lock_sync_q <= 2'h0;
      trk_sync_q  <= 2'h0;
      lock_prev_q <= 1'b0;
    end
    else
    begin
      lock_sync_q <= {lock_sync_q[0], LOCK_DETECT_I};
      trk_sync_q  <= {trk_sync_q[0], TRACKING_I};
      lock_prev_q <= lock_now;
    end
  end

  // Detector only counts while the loop runs in auto mode
  assign lock_now  = lock_sync_q[1] && cfg_q.auto_bw && PLL_ENABLE_O;
  assign lock_edge = lock_now ^ lock_prev_q;

  // Interlocks: each bit judged against the value held before this write
  always_comb
  begin
    new_on  = cfg_q.on;
    new_bcs = cfg_q.base_clock_select;
    if (ctrl_wr)
    begin
      if (PWDATA_I[pbcs_pkg::CTRL_ON_BIT] || !cfg_q.base_clock_select)
        new_on = PWDATA_I[pbcs_pkg::CTRL_ON_BIT];
      if (!PWDATA_I[pbcs_pkg::CTRL_BCS_BIT] || cfg_q.on)
        new_bcs = PWDATA_I[pbcs_pkg::CTRL_BCS_BIT];
    end
    if (STOP_I || range_zero)
      new_bcs = 1'b0;
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RSTN_I)
    begin
      cfg_q.ie      <= 1'b0;
      cfg_q.on      <= 1'b1;
      cfg_q.base_clock_select     <= 1'b0;
      cfg_q.auto_bw <= 1'b0;
      cfg_q.acq_man <= 1'b0;
      cfg_q.mul     <= pbcs_pkg::FIELD_RESET;
      cfg_q.rng     <= pbcs_pkg::FIELD_RESET;
    end
    else
    begin
      cfg_q.on  <= new_on;
      cfg_q.base_clock_select <= new_bcs;
      if (ctrl_wr && cfg_q.auto_bw)
        cfg_q.ie <= PWDATA_I[pbcs_pkg::CTRL_IE_BIT];
      if (bwc_wr)
      begin
        cfg_q.auto_bw <= PWDATA_I[pbcs_pkg::BWC_AUTO_BIT];
        // Manual value is kept aside while auto mode owns the bit
        if (!cfg_q.auto_bw)
          cfg_q.acq_man <= PWDATA_I[pbcs_pkg::BWC_ACQ_BIT];
      end
      if (prog_wr && !cfg_q.on)
      begin
        cfg_q.mul <= PWDATA_I[pbcs_pkg::PROG_MUL_LSB +: 4];
        cfg_q.rng <= PWDATA_I[pbcs_pkg::PROG_RNG_LSB +: 4];
      end
    end
  end

  // Only a flag that the read returned is cleared; a toggle after the capture survives
  assign flag_read = rd_en && (PADDR_I == pbcs_pkg::CTRL_ADDR) &&
                     PRDATA_O[pbcs_pkg::CTRL_FLAG_BIT];

  always_ff @(posedge CLK_I)
  begin
    if (!RSTN_I)
      flag_q <= 1'b0;
    else if (lock_edge && cfg_q.auto_bw)
      flag_q <= 1'b1;
    else if (flag_read || !cfg_q.auto_bw)
      flag_q <= 1'b0;
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RSTN_I)
      PLL_INTERRUPT_REQUEST_O <= 1'b0;
    else
      PLL_INTERRUPT_REQUEST_O <= flag_q && cfg_q.ie && cfg_q.auto_bw && !STOP_I;
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RSTN_I)
      PRDATA_O <= 32'h0;
    else if (rd_setup)
    begin
      PRDATA_O <= 32'h0;
      case (PADDR_I)
        pbcs_pkg::CTRL_ADDR:
          PRDATA_O[7:0] <= {cfg_q.ie && cfg_q.auto_bw, flag_q && cfg_q.auto_bw,
                            cfg_q.on, cfg_q.base_clock_select, pbcs_pkg::CTRL_UNIMP_VAL};
        pbcs_pkg::BWC_ADDR:
        begin
          PRDATA_O[pbcs_pkg::BWC_AUTO_BIT] <= cfg_q.auto_bw;
          PRDATA_O[pbcs_pkg::BWC_LOCK_BIT] <= lock_now;
          PRDATA_O[pbcs_pkg::BWC_ACQ_BIT]  <= cfg_q.auto_bw ? trk_sync_q[1]
                                                             : cfg_q.acq_man;
        end
        pbcs_pkg::PROG_ADDR:
          PRDATA_O[7:0] <= {cfg_q.mul, cfg_q.rng};
        default:
          PRDATA_O <= 32'h0;
      endcase
    end
  end

  assign OSC_ENABLE_O   = OSCILLATOR_ENABLE_IN_I;
  assign PLL_ENABLE_O   = OSCILLATOR_ENABLE_IN_I && cfg_q.on && !range_zero;
  assign AUTO_BW_O      = cfg_q.auto_bw;
  assign ACQ_CTRL_O     = cfg_q.acq_man;
  assign RANGE_SELECT_O = cfg_q.rng;
  assign FEEDBACK_DIV_O = (cfg_q.mul == pbcs_pkg::FIELD_ZERO) ? pbcs_pkg::MUL_ONE : cfg_q.mul;

  // Glitch-free switch: each side opens on its own falling edges only
  // after the other side has let go, so neither clock is cut mid-pulse.
  logic [pbcs_pkg::SYNC_STAGES-1:0] xs_q;
  logic [pbcs_pkg::SYNC_STAGES-1:0] vs_q;
  logic                             x_req;
  logic                             v_req;
  logic                             gated;
  logic                             div_q;

  assign v_req = sel_vco && PLL_ENABLE_O && !STOP_I;
  assign x_req = !sel_vco && OSCILLATOR_ENABLE_IN_I && !STOP_I;

  always_ff @(negedge CRYSTAL_CLOCK_I)
  begin
    if (!RSTN_I)
      xs_q <= '0;
    else
      xs_q <= {xs_q[pbcs_pkg::SYNC_STAGES-2:0], x_req && !vs_q[pbcs_pkg::SYNC_STAGES-1]};
  end

  always_ff @(negedge VCO_CLOCK_I)
  begin
    if (!RSTN_I)
      vs_q <= '0;
    else
      vs_q <= {vs_q[pbcs_pkg::SYNC_STAGES-2:0], v_req && !xs_q[pbcs_pkg::SYNC_STAGES-1]};
  end

  // Output stays static while neither gate is open
  assign gated = (CRYSTAL_CLOCK_I && xs_q[pbcs_pkg::SYNC_STAGES-1]) ||
                 (VCO_CLOCK_I && vs_q[pbcs_pkg::SYNC_STAGES-1]);

  always_ff @(posedge gated or negedge RSTN_I)
  begin
    if (!RSTN_I)
      div_q <= 1'b0;
    else
      div_q <= !div_q;
  end

  assign BASE_CLOCK_OUT_O = div_q && !STOP_I;

endmodule // pbcs_top

/* testbench/pbcs_far_model.sv */
// Source clocks and lock detector seen by the selector.
// Assumes the VCO runs only while the PLL is enabled.
`timescale 1ns/1ps
module pbcs_far_model
(
  input  wire logic pll_en_i,
  input  wire logic lock_req_i,
  output logic      xtal_o,
  output logic      vco_o,
  output logic      lock_o
);
  initial xtal_o = 1'b0;
  initial vco_o = 1'b0;
  always #50 xtal_o = ~xtal_o;
  // An unknown enable before reset holds the VCO still rather than poisoning it
  always #20 vco_o = (pll_en_i === 1'b1) ? ~vco_o : vco_o;
  // A stopped loop never reports lock
  assign lock_o = lock_req_i & pll_en_i;
endmodule // pbcs_far_model

/* testbench/pbcs_properties.sv */
// Checker for the PLL base clock selector, bound to the top module.
// Assumes the bench keeps the lock level steady around control reads.
`timescale 1ns/1ps
module pbcs_properties
(
  input wire logic        CLK_I,
  input wire logic        RSTN_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [7:0]  PADDR_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic        LOCK_DETECT_I,
  input wire logic        OSCILLATOR_ENABLE_IN_I,
  input wire logic        PLL_INTERRUPT_REQUEST_O,
  input wire logic        OSC_ENABLE_O,
  input wire logic        PLL_ENABLE_O,
  input wire logic        AUTO_BW_O,
  input wire logic [3:0]  FEEDBACK_DIV_O,
  input wire logic [3:0]  RANGE_SELECT_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);
  wire rd_go = PSEL_I & PENABLE_I & ~PWRITE_I;
  wire rd_ctl = rd_go & (PADDR_I == pbcs_pkg::CTRL_ADDR);
  wire rd_bw  = rd_go & (PADDR_I == pbcs_pkg::BWC_ADDR);
  property p_osc; OSC_ENABLE_O == OSCILLATOR_ENABLE_IN_I; endproperty
  a_osc: assert property (p_osc) else $error("osc enable mismatch");
  property p_en; PLL_ENABLE_O |-> OSCILLATOR_ENABLE_IN_I; endproperty
  a_en: assert property (p_en) else $error("pll on without osc");
  property p_rng; RANGE_SELECT_O == 4'h0 |-> !PLL_ENABLE_O; endproperty
  a_rng: assert property (p_rng) else $error("pll on with range zero");
  property p_mul; FEEDBACK_DIV_O != 4'h0; endproperty
  a_mul: assert property (p_mul) else $error("divider zero");
  property p_hold;
    PLL_ENABLE_O |=> $stable(FEEDBACK_DIV_O) && $stable(RANGE_SELECT_O);
  endproperty
  a_hold: assert property (p_hold) else $error("fields moved while on");
  property p_irq; !AUTO_BW_O |=> !PLL_INTERRUPT_REQUEST_O; endproperty
  a_irq: assert property (p_irq) else $error("irq in manual");
  // Lock held steady so no fresh toggle can set the flag again
  property p_clr;
    $stable(LOCK_DETECT_I)[*6] ##0 rd_ctl |-> ##2 !PLL_INTERRUPT_REQUEST_O;
  endproperty
  a_clr: assert property (p_clr) else $error("read left irq");
  // Read data must already stand in the access cycle, where the master takes it
  property p_ones;
    rd_ctl |-> PRDATA_O[3:0] == pbcs_pkg::CTRL_UNIMP_VAL && PRDATA_O[31:8] == 24'h0;
  endproperty
  a_ones: assert property (p_ones) else $error("low bits wrong");
  property p_man; rd_ctl && !AUTO_BW_O |-> PRDATA_O[7:6] == 2'b00; endproperty
  a_man: assert property (p_man) else $error("ie or flag in manual");
  property p_lck; rd_bw && !AUTO_BW_O |-> !PRDATA_O[6]; endproperty
  a_lck: assert property (p_lck) else $error("lock in manual");
endmodule // pbcs_properties
bind pbcs_top pbcs_properties u_chk (.*);

/* testbench/pbcs_top_bench.sv */
// Self-checking bench for the selector: APB tasks, scenarios, verdict.
// Assumes a zero-wait APB slave whose read data stands in the access cycle.
`timescale 1ns/1ps
module pbcs_top_bench;
  logic        clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, pready;
  logic        osc = 1, stop = 0, trk = 0, lreq = 0, xtal, vco, lock;
  logic        base, irq, pllen, osco, acqo, slverr;
  logic [3:0]  fdiv;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, d;
  int          fails = 0, checked = 0;
  always #50 clk = ~clk;
  pbcs_far_model far (.pll_en_i(pllen), .lock_req_i(lreq), .xtal_o(xtal),
    .vco_o(vco), .lock_o(lock));
  pbcs_top uut (.CLK_I(clk), .RSTN_I(rstn), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(slverr), .CRYSTAL_CLOCK_I(xtal), .VCO_CLOCK_I(vco),
    .LOCK_DETECT_I(lock), .TRACKING_I(trk), .OSCILLATOR_ENABLE_IN_I(osc),
    .STOP_I(stop), .BASE_CLOCK_OUT_O(base), .PLL_INTERRUPT_REQUEST_O(irq),
    .OSC_ENABLE_O(osco), .PLL_ENABLE_O(pllen), .AUTO_BW_O(), .ACQ_CTRL_O(acqo),
    .FEEDBACK_DIV_O(fdiv), .RANGE_SELECT_O());
  task automatic chk(input string n, input logic [31:0] e, g);
    checked++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("read data", e, rd);
    chk("slave error", 0, slverr);
  endtask
  task automatic per(input int p);
    realtime t0, t1;
    repeat (20) @(posedge clk);
    @(posedge base) t0 = $realtime;
    @(negedge base) t1 = $realtime;
    chk("base high", p / 2, int'(t1 - t0));
    @(posedge base) chk("base period", p, int'($realtime - t0));
  endtask
  task automatic close_out;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    #500000;
    fails++;
    close_out;
  end
  initial
  begin
    d = $urandom(32'he5113b06);
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    rdc(8'h00, 8'h2f);
    rdc(8'h04, 8'h00);
    rdc(8'h08, 8'h66);
    rdc(8'h0c, 8'h00);
    per(200);
    $display("reset and crystal test done");
    apb(1'b1, 8'h00, 8'h30);
    rdc(8'h00, 8'h3f);
    per(80);
    apb(1'b1, 8'h00, 8'h10);
    rdc(8'h00, 8'h3f);
    stop <= 1'b1;
    repeat (4) @(posedge clk);
    chk("base in stop", 0, base);
    stop <= 1'b0;
    rdc(8'h00, 8'h2f);
    apb(1'b1, 8'h00, 8'h00);
    rdc(8'h00, 8'h0f);
    apb(1'b1, 8'h00, 8'h30);
    rdc(8'h00, 8'h2f);
    apb(1'b1, 8'h00, 8'h30);
    rdc(8'h00, 8'h3f);
    apb(1'b1, 8'h00, 8'h20);
    rdc(8'h00, 8'h2f);
    $display("select interlock test done");
    repeat (8)
    begin
      d = $urandom;
      apb(1'b1, 8'h08, d);
      rdc(8'h08, 8'h66);
      apb(1'b1, 8'h04, d & 32'h20);
      rdc(8'h04, d & 32'h20);
      chk("acq ctrl", d[5], acqo);
    end
    apb(1'b1, 8'h04, 8'h00);
    apb(1'b1, 8'h00, 8'h00);
    apb(1'b1, 8'h08, 8'h05);
    @(negedge clk);
    chk("feedback div", 1, fdiv);
    apb(1'b1, 8'h08, 8'h70);
    apb(1'b1, 8'h00, 8'h20);
    @(negedge clk);
    chk("pll enable", 0, pllen);
    apb(1'b1, 8'h00, 8'h30);
    rdc(8'h00, 8'h2f);
    apb(1'b1, 8'h00, 8'h00);
    apb(1'b1, 8'h08, 8'h66);
    apb(1'b1, 8'h00, 8'h20);
    $display("programming test done");
    apb(1'b1, 8'h00, 8'ha0);
    rdc(8'h00, 8'h2f);
    apb(1'b1, 8'h04, 8'h80);
    lreq <= 1'b1;
    trk <= 1'b1;
    repeat (8) @(posedge clk);
    rdc(8'h04, 8'he0);
    apb(1'b1, 8'h04, 8'ha0);
    rdc(8'h04, 8'he0);
    chk("acq ctrl", 0, acqo);
    apb(1'b1, 8'h00, 8'ha0);
    repeat (2) @(negedge clk);
    chk("irq", 1, irq);
    rdc(8'h00, 8'hef);
    rdc(8'h00, 8'haf);
    chk("irq", 0, irq);
    lreq <= 1'b0;
    repeat (8) @(negedge clk);
    chk("irq", 1, irq);
    apb(1'b1, 8'h04, 8'h00);
    rdc(8'h00, 8'h2f);
    rdc(8'h04, 8'h00);
    $display("lock flag test done");
    osc <= 1'b0;
    @(negedge clk);
    chk("pll enable", 0, pllen);
    chk("osc enable", 0, osco);
    @(posedge clk);
    osc <= 1'b1;
    $display("oscillator test done");
    close_out;
  end
endmodule // pbcs_top_bench
